// ===== logic/dca_defs.svh
// Constants for the DDR3 core access pair: timing counts, burst lengths, address bits, core depth.
// Assumes both ends run from one 100 MHz system clock.
`ifndef DCA_DEFS_SVH
`define DCA_DEFS_SVH
`define DCA_CLK_MHZ     100
`define DCA_T_RESET_US  200
`define DCA_T_INIT_US   500
`define DCA_T_CKE_NS    10
`define DCA_RESET_CYC   (`DCA_T_RESET_US * `DCA_CLK_MHZ)
`define DCA_INIT_CYC    (`DCA_T_INIT_US * `DCA_CLK_MHZ)
`define DCA_CKE_CYC     ((`DCA_T_CKE_NS * `DCA_CLK_MHZ + 999) / 1000)
`define DCA_RD_LAT      4'd2
`define DCA_WR_LAT      4'd1
`define DCA_BL_FULL     4'd8
`define DCA_BL_CHOP     4'd4
`define DCA_AP_BIT      10
`define DCA_BC_BIT      12
`define DCA_WORDS       32
`endif

// ===== logic/dca_pkg.sv
// Types and shared decoders for the DDR3 core access pair.
// Assumes dca_defs.svh is included by the files that need numbers.
package dca_pkg;
  // Command code on {row strobe, column strobe, write enable}.
  typedef enum logic [2:0] {
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR  = 3'b100,
    CMD_RD  = 3'b101,
    CMD_NOP = 3'b111
  } dca_cmd_t;

  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_RLAT = 2'b01,
    DS_RBST = 2'b10,
    DS_WBST = 2'b11
  } dca_dst_t;

  typedef enum logic [2:0] {
    CS_RST  = 3'b000,
    CS_INIT = 3'b001,
    CS_NOPW = 3'b010,
    CS_IDLE = 3'b011,
    CS_ACT  = 3'b100,
    CS_RW   = 3'b101,
    CS_WDAT = 3'b110,
    CS_RDAT = 3'b111
  } dca_cst_t;

  // Sequential burst order: column slot of beat i from start column st.
  function automatic logic [2:0] dca_slot(input logic [2:0] st, input logic [2:0] i);
    dca_slot = {st[2] ^ i[2], st[1:0] + i[1:0]};
  endfunction

  // Differential strobe level; a pair with equal legs keeps the old level.
  function automatic logic dca_lvl(input logic t, input logic c, input logic prev);
    dca_lvl = (t != c) ? t : prev;
  endfunction
endpackage

// ===== logic/dca_if.sv
// Link between the controller end and the device end of the DDR3 pair.
// Assumes each end drives only its own output/enable signals.
`timescale 1ns/1ps
interface dca_if;
  logic        ck;
  logic        cke;
  logic        mem_rst_b;
  logic        cs_b;
  logic        ras_b;
  logic        cas_b;
  logic        we_b;
  logic [2:0]  bank_select_lines;
  logic [12:0] row_column_address_lines;
  logic [15:0] ctl_dq_o;
  logic [1:0]  ctl_dq_oe;
  logic [1:0]  ctl_dqs_t;
  logic [1:0]  ctl_dqs_c;
  logic [1:0]  ctl_dqs_oe;
  logic [15:0] dev_dq_o;
  logic [1:0]  dev_dq_oe;
  logic [1:0]  dev_dqs_t;
  logic [1:0]  dev_dqs_c;
  logic [1:0]  dev_dqs_oe;
  wire  [7:0]  lower_data_byte;
  wire  [7:0]  upper_data_byte;
  wire  [1:0]  lower_strobe_pair;
  wire  [1:0]  upper_strobe_pair;

  // Undriven data reads zero and an undriven strobe pair reads true low.
  assign lower_data_byte   = dev_dq_oe[0] ? dev_dq_o[7:0] :
                             ctl_dq_oe[0] ? ctl_dq_o[7:0] : 8'h00;
  assign upper_data_byte   = dev_dq_oe[1] ? dev_dq_o[15:8] :
                             ctl_dq_oe[1] ? ctl_dq_o[15:8] : 8'h00;
  assign lower_strobe_pair = dev_dqs_oe[0] ? {dev_dqs_t[0], dev_dqs_c[0]} :
                             ctl_dqs_oe[0] ? {ctl_dqs_t[0], ctl_dqs_c[0]} : 2'b01;
  assign upper_strobe_pair = dev_dqs_oe[1] ? {dev_dqs_t[1], dev_dqs_c[1]} :
                             ctl_dqs_oe[1] ? {ctl_dqs_t[1], ctl_dqs_c[1]} : 2'b01;

  modport dev (
    input  ck, cke, mem_rst_b, cs_b, ras_b, cas_b, we_b,
    input  bank_select_lines, row_column_address_lines,
    input  lower_data_byte, upper_data_byte, lower_strobe_pair, upper_strobe_pair,
    output dev_dq_o, dev_dq_oe, dev_dqs_t, dev_dqs_c, dev_dqs_oe
  );

  modport ctl (
    output ck, cke, mem_rst_b, cs_b, ras_b, cas_b, we_b,
    output bank_select_lines, row_column_address_lines,
    input  lower_data_byte, upper_data_byte, lower_strobe_pair, upper_strobe_pair,
    output ctl_dq_o, ctl_dq_oe, ctl_dqs_t, ctl_dqs_c, ctl_dqs_oe
  );
endinterface

// ===== logic/dca_ctl.sv
// Controller end of the DDR3 pair: power-up ordering, command issue, data bursts.
// Assumes the device end on the far side of dca_if; makes the link clock itself.
`timescale 1ns/1ps
`include "dca_defs.svh"
module dca_ctl #(
  parameter int unsigned RESET_CYC = `DCA_RESET_CYC,
  parameter int unsigned INIT_CYC  = `DCA_INIT_CYC
) (
  // System
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Memory link
  dca_if.ctl                lnk,
  // Request
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire logic         req_write,
  input  wire logic         req_autopre,
  input  wire logic         req_chop,
  input  wire logic [2:0]   req_bank,
  input  wire logic [12:0]  req_row,
  input  wire logic [9:0]   req_col,
  input  wire logic [127:0] req_wdata,
  // Answer
  output logic              rsp_valid,
  output logic [127:0]      rsp_rdata,
  output logic              init_done
);
  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  logic [3:0] div_r;
  logic       ck_r;
  wire        ev_fall = div_r == 4'h7;
  wire        ev_half = div_r[2:0] == 3'h7;
  wire        ev_mid  = div_r[2:0] == 3'h3;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_r <= 4'h0;
      ck_r  <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      if (ev_half) ck_r <= div_r[3];
    end
  end

  // ----------------------------------------------------------------
  // Read data synchroniser and strobe edges
  // ----------------------------------------------------------------
  logic [19:0] in_s1_r;
  logic [19:0] in_s2_r;
  logic [1:0]  lvl_r;
  logic [1:0]  lvl_now;
  logic [1:0]  st_edge;
  logic [1:0]  lane_done;
  logic [1:0][3:0] rcnt_r;
  logic [3:0]  len_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_s1_r <= 20'h00000;
      in_s2_r <= 20'h00000;
    end else begin
      in_s1_r <= {lnk.upper_data_byte, lnk.lower_data_byte,
                  lnk.upper_strobe_pair, lnk.lower_strobe_pair};
      in_s2_r <= in_s1_r;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign lvl_now[g]   = dca_pkg::dca_lvl(in_s2_r[2*g+1], in_s2_r[2*g], lvl_r[g]);
    assign st_edge[g]   = lvl_now[g] ^ lvl_r[g];
    assign lane_done[g] = rcnt_r[g] == len_r;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  dca_pkg::dca_cst_t st_r;
  dca_pkg::dca_cmd_t cmd_r;
  logic [31:0]  cnt_r;
  logic         mrst_r;
  logic         cke_r;
  logic         cs_r;
  logic [2:0]   ba_r;
  logic [12:0]  addr_r;
  logic [7:0]   open_r;
  logic         wr_r;
  logic         ap_r;
  logic         chop_r;
  logic [12:0]  row_r;
  logic [9:0]   col_r;
  logic [127:0] wdata_r;
  logic [127:0] rbuf_r;
  logic [3:0]   lat_r;
  logic [3:0]   beat_r;
  logic [3:0]   tog_r;
  logic [15:0]  dq_r;
  logic         oe_r;
  logic         dqs_r;
  logic         rsp_r;

  assign req_ready = st_r == dca_pkg::CS_IDLE && ev_fall;
  wire   take      = req_ready && req_valid;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= dca_pkg::CS_RST;
      cmd_r <= dca_pkg::CMD_NOP;
      cnt_r <= 32'h0;
      mrst_r <= 1'b0;
      cke_r <= 1'b0;
      cs_r <= 1'b1;
      ba_r <= 3'h0;
      addr_r <= 13'h0000;
      open_r <= 8'h00;
      {wr_r, ap_r, chop_r} <= 3'h0;
      row_r <= 13'h0000;
      col_r <= 10'h000;
      wdata_r <= '0;
      rbuf_r <= '0;
      rsp_rdata <= '0;
      {lat_r, beat_r, tog_r, len_r} <= 16'h0000;
      rcnt_r <= '0;
      lvl_r <= 2'h0;
      dq_r <= 16'h0000;
      {oe_r, dqs_r, rsp_r} <= 3'h0;
    end else begin
      lvl_r <= lvl_now;
      rsp_r <= 1'b0;
      if (ev_fall) cmd_r <= dca_pkg::CMD_NOP;
      unique case (st_r)
        dca_pkg::CS_RST: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= RESET_CYC - 1 && cnt_r >= `DCA_CKE_CYC) begin
            mrst_r <= 1'b1;
            cs_r <= 1'b0;
            cnt_r <= 32'h0;
            st_r <= dca_pkg::CS_INIT;
          end
        end
        dca_pkg::CS_INIT: begin
          if (cnt_r < INIT_CYC - 1) cnt_r <= cnt_r + 32'h1;
          else if (ev_fall) begin
            cke_r <= 1'b1;
            st_r <= dca_pkg::CS_NOPW;
          end
        end
        dca_pkg::CS_NOPW: if (ev_fall) st_r <= dca_pkg::CS_IDLE;
        dca_pkg::CS_IDLE: if (take) begin
          {wr_r, ap_r, chop_r} <= {req_write, req_autopre, req_chop};
          {row_r, col_r, wdata_r} <= {req_row, req_col, req_wdata};
          ba_r <= req_bank;
          addr_r <= open_r[req_bank] ? 13'h0000 : req_row;
          cmd_r <= open_r[req_bank] ? dca_pkg::CMD_PRE : dca_pkg::CMD_ACT;
          open_r[req_bank] <= 1'b0;
          st_r <= open_r[req_bank] ? dca_pkg::CS_ACT : dca_pkg::CS_RW;
        end
        dca_pkg::CS_ACT: if (ev_fall) begin
          cmd_r <= dca_pkg::CMD_ACT;
          addr_r <= row_r;
          st_r <= dca_pkg::CS_RW;
        end
        dca_pkg::CS_RW: if (ev_fall) begin
          cmd_r <= wr_r ? dca_pkg::CMD_WR : dca_pkg::CMD_RD;
          addr_r <= {~chop_r, 1'b0, ap_r, col_r};
          open_r[ba_r] <= ~ap_r;
          len_r <= chop_r ? `DCA_BL_CHOP : `DCA_BL_FULL;
          {lat_r, beat_r, tog_r} <= {`DCA_WR_LAT, 8'h00};
          rcnt_r <= '0;
          rbuf_r <= '0;
          st_r <= wr_r ? dca_pkg::CS_WDAT : dca_pkg::CS_RDAT;
        end
        dca_pkg::CS_WDAT: begin
          if (ev_fall && lat_r != 4'h0) lat_r <= lat_r - 4'h1;
          if (ev_half && lat_r == 4'h0) begin
            if (beat_r == len_r) begin
              oe_r <= 1'b0;
              st_r <= dca_pkg::CS_IDLE;
            end else begin
              dq_r <= wdata_r[{beat_r[2:0], 4'h0} +: 16];
              oe_r <= 1'b1;
              beat_r <= beat_r + 4'h1;
            end
          end
          if (ev_mid && oe_r && tog_r < beat_r) begin
            dqs_r <= ~dqs_r;
            tog_r <= tog_r + 4'h1;
          end
        end
        dca_pkg::CS_RDAT: begin
          for (int i = 0; i < 2; i++) begin
            if (st_edge[i] && !lane_done[i]) begin
              rbuf_r[{rcnt_r[i][2:0], i[0], 3'h0} +: 8] <= in_s2_r[4+8*i +: 8];
              rcnt_r[i] <= rcnt_r[i] + 4'h1;
            end
          end
          if (&lane_done) begin
            rsp_rdata <= rbuf_r;
            rsp_r <= 1'b1;
            st_r <= dca_pkg::CS_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  assign lnk.ck                       = ck_r;
  assign lnk.cke                      = cke_r;
  assign lnk.mem_rst_b                = mrst_r;
  assign lnk.cs_b                     = cs_r;
  assign {lnk.ras_b, lnk.cas_b, lnk.we_b} = cmd_r;
  assign lnk.bank_select_lines        = ba_r;
  assign lnk.row_column_address_lines = addr_r;
  assign lnk.ctl_dq_o                 = dq_r;
  assign lnk.ctl_dq_oe                = {2{oe_r}};
  assign lnk.ctl_dqs_t                = {2{dqs_r}};
  assign lnk.ctl_dqs_c                = {2{~dqs_r}};
  assign lnk.ctl_dqs_oe               = {2{oe_r}};
  assign rsp_valid                    = rsp_r;
  assign init_done                    = st_r != dca_pkg::CS_RST && st_r != dca_pkg::CS_INIT
                                        && st_r != dca_pkg::CS_NOPW;
endmodule // dca_ctl

// ===== logic/dca_dev.sv
// DDR3 device end: command decode, eight-bank core, 8n prefetch, strobed data.
// Assumes the controller end drives the link clock and keeps power-up order.
//
// Functional notes
// - Eight banks, each opened and accessed separately.
// - Core moves eight words at once; pins twice.
// - Bursts of eight or chopped four, fixed order.
// - Controller opens bank with Active before access.
// - Active takes bank and thirteen-bit row.
// - Read/Write takes start column and precharge flag.
// - On-the-fly mode picks burst length per command.
// - Reads strobe edge-aligned; writes strobe centred.
// - Strobes are differential pairs on both sides.
// - Lower strobe times lower byte, upper upper.
// - Controller holds reset low at least 200 us.
// - Clock enable low 10 ns before release.
// - Controller waits 500 us before clock enable.
// - Precharge flag high closes bank after access.
// - Burst-chop line high full, low chopped.
`timescale 1ns/1ps
`include "dca_defs.svh"
module dca_dev (
  // System
  input  wire logic   clk,
  input  wire logic   rst_b,
  // Memory link
  dca_if.dev          lnk,
  // Mode settings
  input  wire logic   mode_otf_en,
  input  wire logic   mode_fixed_chop,
  // Status
  output logic        dev_ready,
  output logic [7:0]  bank_open
);
  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  // Every controller pin crosses through the same two flops, so the
  // data and its strobe keep their relative timing after the crossing.
  logic [42:0] in_raw;
  logic [42:0] in_s1_r;
  logic [42:0] in_s2_r;
  logic        ck_q_r;

  assign in_raw = {lnk.ck, lnk.cke, lnk.mem_rst_b, lnk.cs_b,
                   lnk.ras_b, lnk.cas_b, lnk.we_b,
                   lnk.bank_select_lines, lnk.row_column_address_lines,
                   lnk.upper_data_byte, lnk.lower_data_byte,
                   lnk.upper_strobe_pair, lnk.lower_strobe_pair};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      ck_q_r  <= 1'b0;
    end else begin
      in_s1_r <= in_raw;
      in_s2_r <= in_s1_r;
      ck_q_r  <= in_s2_r[42];
    end
  end

  wire               ck_s   = in_s2_r[42];
  wire               cke_s  = in_s2_r[41];
  wire               mrst_s = in_s2_r[40];
  wire               cs_s   = in_s2_r[39];
  dca_pkg::dca_cmd_t cmd_s;
  wire  [2:0]        ba_s   = in_s2_r[35:33];
  wire  [12:0]       a_s    = in_s2_r[32:20];
  wire  [15:0]       dq_s   = in_s2_r[19:4];
  wire  [3:0]        str_s  = in_s2_r[3:0];
  wire               ck_rise = ck_s & ~ck_q_r;
  wire               ck_edge = ck_s ^ ck_q_r;
  wire               clr     = !rst_b || !mrst_s;

  assign cmd_s = dca_pkg::dca_cmd_t'(in_s2_r[38:36]);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  dca_pkg::dca_dst_t st_r;
  logic        ready_r;
  logic [7:0]  open_r;
  logic [7:0]  row_r;
  logic [4:0]  idx_r;
  logic [2:0]  start_r;
  logic [3:0]  len_r;
  logic        ap_r;

  wire       take   = ck_rise && ready_r && cke_s && !cs_s;
  wire       is_act = take && cmd_s == dca_pkg::CMD_ACT && !open_r[ba_s];
  wire       is_pre = take && cmd_s == dca_pkg::CMD_PRE;
  wire       is_rd  = take && cmd_s == dca_pkg::CMD_RD;
  wire       is_wr  = take && cmd_s == dca_pkg::CMD_WR;
  wire       rw_go  = (is_rd || is_wr) && open_r[ba_s] && st_r == dca_pkg::DS_IDLE;
  wire       chop   = mode_otf_en ? !a_s[`DCA_BC_BIT] : mode_fixed_chop;
  wire [3:0] blen   = chop ? `DCA_BL_CHOP : `DCA_BL_FULL;
  // Core word index: bank, the row bit kept for it, and column above the burst.
  wire [4:0] cidx   = {ba_s, row_r[ba_s], a_s[3]};

  // ----------------------------------------------------------------
  // Write strobe edges per byte lane
  // ----------------------------------------------------------------
  logic [1:0]      lvl_r;
  logic [1:0]      lvl_now;
  logic [1:0]      st_edge;
  logic [1:0]      lane_done;
  logic [1:0][3:0] wcnt_r;
  logic [2:0]      wslot [2];

  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign lvl_now[g]   = dca_pkg::dca_lvl(str_s[2*g+1], str_s[2*g], lvl_r[g]);
    assign st_edge[g]   = lvl_now[g] ^ lvl_r[g];
    assign lane_done[g] = wcnt_r[g] == len_r;
    assign wslot[g]     = dca_pkg::dca_slot(start_r, wcnt_r[g][2:0]);
  end

  // ----------------------------------------------------------------
  // Bank state
  // ----------------------------------------------------------------
  logic [3:0]  beat_r;
  wire         rd_end = st_r == dca_pkg::DS_RBST && ck_edge && beat_r == len_r;
  wire         wr_end = st_r == dca_pkg::DS_WBST && &lane_done;

  always_ff @(posedge clk) begin
    if (clr) begin
      ready_r <= 1'b0;
      open_r  <= 8'h00;
      row_r   <= 8'h00;
    end else begin
      // Commands count only once clock enable is seen high after reset.
      if (ck_rise && cke_s) ready_r <= 1'b1;
      if (is_act) begin
        open_r[ba_s] <= 1'b1;
        row_r[ba_s]  <= a_s[0];
      end
      if (is_pre) open_r <= a_s[`DCA_AP_BIT] ? 8'h00 : open_r & ~(8'h01 << ba_s);
      if ((rd_end || wr_end) && ap_r) open_r[idx_r[4:2]] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Prefetch and burst engine
  // ----------------------------------------------------------------
  // The core holds only a few rows and column blocks per bank; the
  // rest of the address aliases onto them, which is enough to show
  // bank and burst behaviour without a full array of flops.
  logic [127:0] mem_r [`DCA_WORDS];
  logic [127:0] pf_r;
  logic [3:0]   lat_r;
  logic [15:0]  dq_r;
  logic         oe_r;
  logic         dqs_r;
  wire  [2:0]   rslot = dca_pkg::dca_slot(start_r, beat_r[2:0]);

  always_ff @(posedge clk) begin
    if (clr) begin
      st_r    <= dca_pkg::DS_IDLE;
      idx_r   <= 5'h00;
      start_r <= 3'h0;
      len_r   <= `DCA_BL_FULL;
      ap_r    <= 1'b0;
      lat_r   <= 4'h0;
      beat_r  <= 4'h0;
      wcnt_r  <= '0;
      lvl_r   <= 2'h0;
      pf_r    <= '0;
      dq_r    <= 16'h0000;
      oe_r    <= 1'b0;
      dqs_r   <= 1'b0;
    end else begin
      lvl_r <= lvl_now;
      unique case (st_r)
        dca_pkg::DS_IDLE: if (rw_go) begin
          idx_r   <= cidx;
          start_r <= a_s[2:0];
          len_r   <= blen;
          ap_r    <= a_s[`DCA_AP_BIT];
          lat_r   <= `DCA_RD_LAT;
          beat_r  <= 4'h0;
          wcnt_r  <= '0;
          pf_r    <= mem_r[cidx];
          st_r    <= is_rd ? dca_pkg::DS_RLAT : dca_pkg::DS_WBST;
        end
        dca_pkg::DS_RLAT: if (ck_rise) begin
          if (lat_r == 4'h1) st_r <= dca_pkg::DS_RBST;
          else lat_r <= lat_r - 4'h1;
        end
        dca_pkg::DS_RBST: if (ck_edge) begin
          if (beat_r == len_r) begin
            oe_r <= 1'b0;
            st_r <= dca_pkg::DS_IDLE;
          end else begin
            // Data and strobe change on the same clock edge.
            dq_r   <= pf_r[{rslot, 4'h0} +: 16];
            dqs_r  <= ~beat_r[0];
            oe_r   <= 1'b1;
            beat_r <= beat_r + 4'h1;
          end
        end
        dca_pkg::DS_WBST: begin
          for (int i = 0; i < 2; i++) begin
            if (st_edge[i] && !lane_done[i]) begin
              pf_r[{wslot[i], i[0], 3'h0} +: 8] <= dq_s[8*i +: 8];
              wcnt_r[i] <= wcnt_r[i] + 4'h1;
            end
          end
          if (wr_end) st_r <= dca_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // Whole prefetch word goes back to the core at once; a chopped burst
  // rewrites the untouched slots with the values read at the command.
  always_ff @(posedge clk) begin
    if (!clr && wr_end) mem_r[idx_r] <= pf_r;
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  assign lnk.dev_dq_o   = dq_r;
  assign lnk.dev_dq_oe  = {2{oe_r}};
  assign lnk.dev_dqs_t  = {2{dqs_r}};
  assign lnk.dev_dqs_c  = {2{~dqs_r}};
  assign lnk.dev_dqs_oe = {2{oe_r}};
  assign dev_ready      = ready_r;
  assign bank_open      = open_r;
endmodule // dca_dev

// ===== sim/dca_checker.sv
// Checker for the link between the controller and device ends of the DDR3 pair.
// Assumes it sees the signals of the one dca_if instance that joins the two ends.
`timescale 1ns/1ps
module dca_checker #(
  parameter int unsigned RESET_CYC = 40,
  parameter int unsigned INIT_CYC  = 60
) (
  // System
  input wire logic       clk,
  input wire logic       rst_b,
  // Power-up and command
  input wire logic       ck,
  input wire logic       cke,
  input wire logic       mem_rst_b,
  input wire logic       cs_b,
  input wire logic       ras_b,
  input wire logic       cas_b,
  input wire logic       we_b,
  // Data enables and strobes
  input wire logic [1:0] ctl_dq_oe,
  input wire logic [1:0] ctl_dqs_t,
  input wire logic [1:0] ctl_dqs_c,
  input wire logic [1:0] ctl_dqs_oe,
  input wire logic [1:0] dev_dq_oe,
  input wire logic [1:0] dev_dqs_t,
  input wire logic [1:0] dev_dqs_c,
  input wire logic [1:0] dev_dqs_oe
);
  logic [31:0] lo_cnt_r;
  logic [31:0] hi_cnt_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Counts of cycles the memory reset has spent low and high since its last change.
  // Cleared by the bench reset, so neither count can start out unknown.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lo_cnt_r <= 32'h0;
      hi_cnt_r <= 32'h0;
    end else begin
      lo_cnt_r <= mem_rst_b ? 32'h0 : lo_cnt_r + 32'h1;
      hi_cnt_r <= mem_rst_b ? hi_cnt_r + 32'h1 : 32'h0;
    end
  end

  a_reset_hold: assert property ($rose(mem_rst_b) |-> lo_cnt_r >= RESET_CYC)
    else $error("memory reset released too early");
  a_cke_low_first: assert property ($rose(mem_rst_b) |-> !cke && $past(!cke))
    else $error("clock enable not low before reset release");
  a_init_wait: assert property ($rose(cke) |-> hi_cnt_r >= INIT_CYC)
    else $error("clock enable raised too soon");
  a_no_early_cmd: assert property (!cke |-> cs_b || {ras_b, cas_b, we_b} == 3'b111)
    else $error("command issued before initialization");
  a_dev_diff: assert property (((dev_dqs_t ^ dev_dqs_c) & dev_dqs_oe) == dev_dqs_oe)
    else $error("device strobe legs not complementary");
  a_ctl_diff: assert property (((ctl_dqs_t ^ ctl_dqs_c) & ctl_dqs_oe) == ctl_dqs_oe)
    else $error("controller strobe legs not complementary");
  a_one_driver: assert property (((dev_dq_oe | dev_dqs_oe) & (ctl_dq_oe | ctl_dqs_oe)) == 2'b00)
    else $error("both ends drive the data bus");
  a_wr_lane_pair: assert property (ctl_dq_oe == ctl_dqs_oe)
    else $error("write lane driven without its strobe");
  a_ck_half: assert property ($rose(ck) |-> ck [*8] ##1 !ck)
    else $error("link clock high phase wrong");

  cover property ($rose(cke));
  cover property ($rose(ctl_dq_oe[0]));
  cover property ($rose(dev_dqs_oe[1]));
endmodule // dca_checker

// ===== sim/tb.sv
// Testbench joining the controller and device ends of the DDR3 pair.
// Assumes scaled power-up counts; no partner model, the two ends face each other.
`timescale 1ns/1ps
module tb;
  localparam int unsigned RC = 40;
  localparam int unsigned IC = 60;
  localparam logic [127:0] W = 128'h7f70_6e60_5d50_4c40_3b30_2a20_1910_0800;
  localparam logic [127:0] Z = 128'hf7e6_d5c4_b3a2_9180_f7e6_d5c4_b3a2_9180;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         req_valid = 1'b0;
  logic         req_write = 1'b0;
  logic         req_autopre = 1'b0;
  logic         req_chop = 1'b0;
  logic [2:0]   req_bank = 3'h0;
  logic [12:0]  req_row = 13'h0;
  logic [9:0]   req_col = 10'h0;
  logic [127:0] req_wdata = 128'h0;
  logic         mode_otf_en = 1'b1;
  logic         mode_fixed_chop = 1'b0;
  logic         req_ready;
  logic         rsp_valid;
  logic         init_done;
  logic         dev_ready;
  logic [127:0] rsp_rdata;
  logic [7:0]   bank_open;
  int           n_errors = 0;
  int           check_count = 0;
  int           cyc = 0;

  dca_if lnk_if ();
  dca_ctl #(.RESET_CYC(RC), .INIT_CYC(IC)) dca_ctl_i (.clk, .rst_b, .lnk(lnk_if),
    .req_valid, .req_ready, .req_write, .req_autopre, .req_chop, .req_bank, .req_row,
    .req_col, .req_wdata, .rsp_valid, .rsp_rdata, .init_done);
  dca_dev dca_dev_i (.clk, .rst_b, .lnk(lnk_if), .mode_otf_en, .mode_fixed_chop,
    .dev_ready, .bank_open);
  dca_checker #(.RESET_CYC(RC), .INIT_CYC(IC)) dca_checker_i (.clk, .rst_b,
    .ck(lnk_if.ck), .cke(lnk_if.cke), .mem_rst_b(lnk_if.mem_rst_b), .cs_b(lnk_if.cs_b),
    .ras_b(lnk_if.ras_b), .cas_b(lnk_if.cas_b), .we_b(lnk_if.we_b),
    .ctl_dq_oe(lnk_if.ctl_dq_oe), .ctl_dqs_t(lnk_if.ctl_dqs_t), .ctl_dqs_c(lnk_if.ctl_dqs_c),
    .ctl_dqs_oe(lnk_if.ctl_dqs_oe), .dev_dq_oe(lnk_if.dev_dq_oe),
    .dev_dqs_t(lnk_if.dev_dqs_t), .dev_dqs_c(lnk_if.dev_dqs_c),
    .dev_dqs_oe(lnk_if.dev_dqs_oe));

  always #5 clk = ~clk;

  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One access; a read returns once the answer pulse has been seen.
  // A wait that runs out is counted as a mismatch.
  task automatic access(input logic wr, ap, ch, input logic [2:0] b, input logic [12:0] r,
                        input logic [9:0] c, input logic [127:0] d);
    int i;
    i = 0;
    @(posedge clk);
    req_write <= wr;
    req_autopre <= ap;
    req_chop <= ch;
    req_bank <= b;
    req_row <= r;
    req_col <= c;
    req_wdata <= d;
    req_valid <= 1'b1;
    do @(negedge clk); while (req_ready !== 1'b1 && ++i < 2000);
    chk(128'(req_ready), 128'h1);
    @(posedge clk);
    req_valid <= 1'b0;
    i = 0;
    if (!wr) begin
      do @(negedge clk); while (rsp_valid !== 1'b1 && ++i < 2000);
      chk(128'(rsp_valid), 128'h1);
    end
  endtask

  task automatic t_power;
    int i;
    i = 0;
    do @(negedge clk); while (init_done !== 1'b1 && ++i < 1000);
    repeat (48) @(negedge clk);
    chk(128'({init_done, dev_ready, lnk_if.cke, lnk_if.mem_rst_b}), 128'hf);
    $display("test power done");
  endtask

  task automatic t_full;
    access(1'b1, 1'b0, 1'b0, 3'h3, 13'h1, 10'h0, W);
    access(1'b0, 1'b0, 1'b0, 3'h3, 13'h1, 10'h0, 128'h0);
    chk(rsp_rdata, W);
    chk(128'(bank_open), 128'h08);
    $display("test full done");
  endtask

  task automatic t_chop;
    access(1'b1, 1'b0, 1'b1, 3'h3, 13'h1, 10'h0, Z);
    access(1'b0, 1'b0, 1'b0, 3'h3, 13'h1, 10'h0, 128'h0);
    chk(rsp_rdata, {W[127:64], Z[63:0]});
    access(1'b0, 1'b1, 1'b1, 3'h3, 13'h1, 10'h5, 128'h0);
    chk(rsp_rdata, {64'h0, W[79:64], W[127:112], W[111:96], W[95:80]});
    // The device closes the bank only at the link clock edge after its last beat.
    repeat (16) @(negedge clk);
    chk(128'(bank_open), 128'h0);
    $display("test chop done");
  endtask

  task automatic t_fixed;
    @(posedge clk);
    mode_otf_en <= 1'b0;
    mode_fixed_chop <= 1'b1;
    // The controller must expect the fixed length, or it waits for beats that never come.
    access(1'b0, 1'b1, 1'b1, 3'h3, 13'h1, 10'h0, 128'h0);
    chk(rsp_rdata, {64'h0, Z[63:0]});
    @(posedge clk);
    mode_otf_en <= 1'b1;
    mode_fixed_chop <= 1'b0;
    $display("test fixed done");
  endtask

  task automatic t_banks;
    for (int b = 0; b < 8; b++)
      access(1'b1, 1'b1, 1'b0, 3'(b), 13'h0, 10'h8, {16{3'(b), 5'h15}});
    for (int b = 0; b < 8; b++) begin
      access(1'b0, 1'b1, 1'b0, 3'(b), 13'h0, 10'h8, 128'h0);
      chk(rsp_rdata, {16{3'(b), 5'h15}});
    end
    $display("test banks done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(128'({lnk_if.cke, lnk_if.mem_rst_b}), 128'h0);
    t_power;
    t_full;
    t_chop;
    t_fixed;
    t_banks;
    tally_and_finish;
  end
endmodule // tb
